// ==== verilog/scrs_host.sv ====
// host end: turns recording jobs into link command sequences
`timescale 1ns/1ps
module scrs_host
  import scrs_pkg::*;
#(
  parameter int unsigned SPEED_CLASS = 10,
  parameter int unsigned AU_KB = AU_MAX_KB,
  parameter int unsigned CLUSTER_BLK = CLUSTER_BLK_DEF,
  parameter int unsigned LCLK_HALF = (CLK_MHZ - 1) / (2 * scrs_bus_mhz(SPEED_CLASS))
) (
  input wire logic CLOCK,
  input wire logic RST,
  scrs_link_if.host lnk,
  input wire logic JOB_VALID,
  output logic JOB_READY,
  input wire scrs_job_t JOB_OP,
  input wire logic [31:0] JOB_ADDR,
  input wire logic [15:0] JOB_LEN,
  input wire logic [31:0] JOB_ADDR2,
  input wire logic [15:0] JOB_LEN2,
  output logic JOB_DONE,
  output logic JOB_ERR
);
  localparam logic [15:0] RU_BLK = scrs_ru_blocks(SPEED_CLASS);
  localparam logic [31:0] AU_BLK = 32'(AU_KB * BLK_PER_KB);
  localparam logic [31:0] CL_BLK = 32'(CLUSTER_BLK);
  localparam logic [15:0] HALF_M1 = 16'(LCLK_HALF - 1);

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_SEND = 3'h1,
    H_HOLD = 3'h2,
    H_GUARD = 3'h3,
    H_WAIT = 3'h4
  } scrs_hstate_t;

  typedef struct packed {
    scrs_link_t out;
    logic [15:0] div;
    logic bsy1;
    logic bsy2;
    scrs_hstate_t st;
    scrs_job_t job;
    logic [31:0] j_addr;
    logic [15:0] j_len;
    logic [31:0] j_addr2;
    logic [15:0] j_len2;
    logic [1:0] step;
    logic [3:0] gcnt;
    logic dir_ok;
    logic [31:0] dir_addr;
    logic rec;
    logic [31:0] au_ptr;
    logic [31:0] au_left;
    logic ci_open;
    logic [31:0] ci_addr;
    logic [31:0] ci_left;
    logic rdy;
    logic done;
    logic err;
  } scrs_host_st_t;

  scrs_host_st_t q, d;

  always_comb begin
    logic toggle;
    logic fall;
    logic bad;
    logic [1:0] last;
    scrs_op_t c_op;
    logic [31:0] c_addr;
    logic [15:0] c_len;
    bad = 1'b0;
    d = q;
    d.done = 1'b0;
    d.err = 1'b0;
    d.bsy1 = lnk.busy;
    d.bsy2 = q.bsy1;
    toggle = (q.div == HALF_M1);
    fall = toggle & q.out.lclk;
    d.div = toggle ? 16'h0000 : q.div + 16'h0001;
    if (toggle) begin
      d.out.lclk = ~q.out.lclk;
    end
    c_op = OP_WRITE;
    c_addr = q.j_addr;
    c_len = q.j_len;
    last = 2'h0;
    unique case (q.job)
      J_DIR: begin
        last = 2'h1;
        if (q.step == 2'h0) begin
          c_op = OP_UPDATE_DIR;
        end
        c_len = 16'(ENTRY_BLK);
      end
      J_START: begin
        c_op = OP_START_REC;
      end
      J_RU: begin
        c_len = RU_BLK;
      end
      J_TABLE: begin
        last = 2'h2;
        if (q.step == 2'h1) begin
          c_addr = q.j_addr2;
          c_len = q.j_len2;
        end else if (q.step == 2'h2) begin
          c_addr = q.dir_addr;
          c_len = 16'(ENTRY_BLK);
        end
      end
      J_CI: begin
        last = 2'h1;
        if (q.step == 2'h0) begin
          c_op = OP_UPDATE_CI;
        end
        c_len = 16'(ENTRY_BLK);
      end
      default: begin
        c_op = OP_IDLE;
      end
    endcase

    unique case (q.st)
      H_IDLE: begin
        if (JOB_VALID && q.rdy) begin
          bad = 1'b0;
          d.job = JOB_OP;
          d.j_addr = JOB_ADDR;
          d.j_len = JOB_LEN;
          d.j_addr2 = JOB_ADDR2;
          d.j_len2 = JOB_LEN2;
          d.step = 2'h0;
          unique case (JOB_OP)
            J_DIR: begin
              d.rec = 1'b0;
              d.dir_addr = JOB_ADDR;
            end
            J_START: begin
              bad = ~q.dir_ok;
              d.rec = q.dir_ok;
              d.ci_open = 1'b0;
            end
            J_RU: begin
              bad = ~q.rec;
              // a new unit is taken only when the current one is full
              if (q.au_left == 32'h0) begin
                d.j_addr = JOB_ADDR;
                d.au_ptr = JOB_ADDR + 32'(RU_BLK);
                d.au_left = AU_BLK - 32'(RU_BLK);
              end else begin
                d.j_addr = q.au_ptr;
                d.au_ptr = q.au_ptr + 32'(RU_BLK);
                d.au_left = q.au_left - 32'(RU_BLK);
              end
            end
            J_TABLE: begin
              bad = ~q.rec || ~q.dir_ok || (JOB_LEN > 16'(FAT_MAX_BLK)) ||
                (JOB_LEN2 < 16'(BMP_MIN_BLK)) || (JOB_LEN2 > 16'(FAT_MAX_BLK));
            end
            J_CI: begin
              // allowed outside recording too, where it costs no stream time
              bad = ~q.dir_ok;
              if (!q.ci_open) begin
                d.ci_open = 1'b1;
                d.ci_addr = JOB_ADDR;
                d.ci_left = CL_BLK - (JOB_ADDR % CL_BLK);
              end else if (JOB_LEN != 16'h0000) begin
                if (q.ci_left == 32'h1) begin
                  bad = (JOB_ADDR % CL_BLK) != 32'h0;
                  d.ci_addr = JOB_ADDR;
                  d.ci_left = CL_BLK;
                end else begin
                  d.ci_addr = q.ci_addr + 32'h1;
                  d.ci_left = q.ci_left - 32'h1;
                end
              end
              d.j_addr = d.ci_addr;
            end
            default: begin
              bad = 1'b1;
            end
          endcase
          if (bad) begin
            d = q;
            d.div = toggle ? 16'h0000 : q.div + 16'h0001;
            d.out.lclk = toggle ? ~q.out.lclk : q.out.lclk;
            d.bsy1 = lnk.busy;
            d.bsy2 = q.bsy1;
            d.done = 1'b0;
            d.err = 1'b1;
          end else begin
            d.st = H_SEND;
          end
        end
      end
      H_SEND: begin
        // link fields change on the falling edge, card samples on rising
        if (fall) begin
          d.out.valid = 1'b1;
          d.out.op = c_op;
          d.out.addr = c_addr;
          d.out.len = c_len;
          d.st = H_HOLD;
        end
      end
      H_HOLD: begin
        if (fall) begin
          d.out.valid = 1'b0;
          d.gcnt = 4'(GUARD_CYC);
          d.st = H_GUARD;
        end
      end
      H_GUARD: begin
        // covers the card's sync delay before its busy can be seen
        d.gcnt = q.gcnt - 4'h1;
        if (q.gcnt == 4'h1) begin
          d.st = H_WAIT;
        end
      end
      H_WAIT: begin
        if (!q.bsy2) begin
          if (q.step == last) begin
            d.st = H_IDLE;
            d.done = 1'b1;
            if (q.job == J_DIR) begin
              d.dir_ok = 1'b1;
            end
          end else begin
            d.step = q.step + 2'h1;
            d.st = H_SEND;
          end
        end
      end
      default: begin
        d.st = H_IDLE;
      end
    endcase
    d.rdy = (d.st == H_IDLE) && !d.err;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lnk.cmd = q.out;
  assign JOB_READY = q.rdy;
  assign JOB_DONE = q.done;
  assign JOB_ERR = q.err;
endmodule

// ==== pkg/scrs_pkg.sv ====
// shared constants and types for the class recording sequencer ends
package scrs_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
  localparam int unsigned BLK_BYTES = 512;
  localparam int unsigned BLK_PER_KB = 1024 / BLK_BYTES;
  localparam int unsigned AU_MAX_KB = 65536;
  localparam int unsigned SUB_KB = 4096;
  localparam int unsigned RU_KB_STD = 256;
  localparam int unsigned RU_KB_C10 = 512;
  localparam int unsigned FAT_MAX_KB = 16;
  localparam int unsigned FAT_MAX_BLK = FAT_MAX_KB * BLK_PER_KB;
  localparam int unsigned BMP_MIN_BYTES = 512;
  localparam int unsigned BMP_MIN_BLK = BMP_MIN_BYTES / BLK_BYTES;
  localparam int unsigned ENTRY_BLK = 1;
  localparam int unsigned TFW_DEPTH = 8;
  localparam int unsigned TFW_SHIFT = 3;
  localparam int unsigned UPD_BUSY_MS = 10;
  localparam int unsigned REC_BUSY_MS = 1000;
  localparam int unsigned CI_OP_MS = 250;
  localparam int unsigned UPD_BUSY_CYC = UPD_BUSY_MS * CYC_PER_MS;
  localparam int unsigned REC_BUSY_CYC = REC_BUSY_MS * CYC_PER_MS;
  localparam int unsigned CI_OP_CYC = CI_OP_MS * CYC_PER_MS;
  localparam int unsigned BUS_MHZ_STD = 20;
  localparam int unsigned BUS_MHZ_HS = 40;
  localparam int unsigned GUARD_CYC = 8;
  localparam int unsigned CLUSTER_BLK_DEF = 64;
  localparam logic [7:0] MOVE_RATE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    OP_IDLE = 3'h0,
    OP_WRITE = 3'h1,
    OP_START_REC = 3'h2,
    OP_UPDATE_DIR = 3'h3,
    OP_UPDATE_CI = 3'h4
  } scrs_op_t;

  typedef enum logic [2:0] {
    WK_PLAIN = 3'h0,
    WK_STREAM = 3'h1,
    WK_TABLE = 3'h2,
    WK_DIR = 3'h3,
    WK_CI = 3'h4
  } scrs_kind_t;

  typedef enum logic [2:0] {
    J_DIR = 3'h0,
    J_START = 3'h1,
    J_RU = 3'h2,
    J_TABLE = 3'h3,
    J_CI = 3'h4
  } scrs_job_t;

  typedef struct packed {
    logic lclk;
    logic valid;
    scrs_op_t op;
    logic [31:0] addr;
    logic [15:0] len;
  } scrs_link_t;

  function automatic logic [15:0] scrs_ru_blocks(input int unsigned cls);
    return 16'(((cls >= 10) ? RU_KB_C10 : RU_KB_STD) * BLK_PER_KB);
  endfunction

  function automatic int unsigned scrs_bus_mhz(input int unsigned cls);
    return (cls >= 10) ? BUS_MHZ_HS : BUS_MHZ_STD;
  endfunction
endpackage

// ==== pkg/scrs_link_if.sv ====
// link between the recording host and the card
`timescale 1ns/1ps
interface scrs_link_if;
  import scrs_pkg::*;
  scrs_link_t cmd;
  logic busy;
  modport host (output cmd, input busy);
  modport card (input cmd, output busy);
endinterface

// ==== verilog/scrs_card.sv ====
// card end: classifies writes, keeps busy timing and performance figures
`timescale 1ns/1ps
module scrs_card
  import scrs_pkg::*;
#(
  parameter int unsigned SPEED_CLASS = 10,
  parameter int unsigned AU_KB = AU_MAX_KB,
  parameter int unsigned WRITE_RATE = 10,
  parameter int unsigned READ_RATE = 10,
  parameter int unsigned BLK_CYC = 1,
  parameter int unsigned UPD_CYC = UPD_BUSY_CYC,
  parameter int unsigned REC_CYC = REC_BUSY_CYC,
  parameter int unsigned CI_CYC = CI_OP_CYC
) (
  input wire logic CLOCK,
  input wire logic RST,
  scrs_link_if.card lnk,
  output logic WR_VALID,
  output scrs_kind_t WR_KIND,
  output logic [31:0] WR_ADDR,
  output logic [15:0] WR_LEN,
  output logic RECORDING,
  output logic SUB_DONE,
  output logic [31:0] SUB_CYCLES,
  output logic [31:0] TFW_AVE,
  output logic [7:0] MOVE_RATE,
  output logic [7:0] WRITE_RATE_MIN,
  output logic [7:0] READ_RATE_MIN,
  output logic [15:0] RU_BLOCKS,
  output logic [7:0] BUS_MHZ,
  output logic [3:0] CLASS_MASK,
  output logic AU_OK
);
  localparam logic [31:0] SUB_BLOCKS =
    32'(((AU_KB <= SUB_KB) ? AU_KB : SUB_KB) * BLK_PER_KB);
  localparam logic AU_VALID = (AU_KB <= AU_MAX_KB) &&
    ((AU_KB <= SUB_KB) || ((AU_KB % SUB_KB) == 0));
  localparam logic [3:0] CLS_MASK = (SPEED_CLASS >= 10) ? 4'hF :
    (SPEED_CLASS >= 6) ? 4'h7 : (SPEED_CLASS >= 4) ? 4'h3 : 4'h1;
  localparam int unsigned RD_RATE = (READ_RATE > WRITE_RATE) ? READ_RATE : WRITE_RATE;

  typedef struct packed {
    scrs_link_t sy1;
    scrs_link_t sy2;
    logic lclk_p;
    logic busy;
    logic [31:0] busy_cnt;
    logic rec;
    logic ci_arm;
    logic dir_arm;
    logic dir_ok;
    logic [31:0] dir_addr;
    logic stream_on;
    logic table_on;
    logic dir_close;
    logic wr_valid;
    scrs_kind_t wr_kind;
    logic [31:0] wr_addr;
    logic [15:0] wr_len;
    logic [31:0] sub_blk;
    logic [31:0] sub_cyc;
    logic sub_done;
    logic [31:0] sub_res;
    logic [31:0] tfw_acc;
    logic [TFW_DEPTH-1:0][31:0] tfw_hist;
    logic [3:0] tfw_n;
    logic [31:0] tfw_ave;
    logic au_ok;
    logic [3:0] cls_mask;
    logic [15:0] ru_blk;
    logic [7:0] bus_mhz;
    logic [7:0] wr_rate;
    logic [7:0] rd_rate;
    logic [7:0] mv_rate;
  } scrs_card_st_t;

  scrs_card_st_t q, d;

  always_comb begin
    logic [34:0] sum;
    logic edge_l;
    logic take;
    logic [31:0] wcyc;
    sum = '0;
    d = q;
    // link bits are stable around the rising edge, so one wide sync suffices
    d.sy1 = lnk.cmd;
    d.sy2 = q.sy1;
    d.lclk_p = q.sy2.lclk;
    d.wr_valid = 1'b0;
    d.sub_done = 1'b0;
    edge_l = q.sy2.lclk & ~q.lclk_p;
    take = edge_l & q.sy2.valid & ~q.busy;
    wcyc = (q.sy2.len == 16'h0000) ? 32'h1 : 32'(q.sy2.len) * 32'(BLK_CYC);
    d.au_ok = AU_VALID;
    d.cls_mask = CLS_MASK;
    d.ru_blk = scrs_ru_blocks(SPEED_CLASS);
    d.bus_mhz = 8'(scrs_bus_mhz(SPEED_CLASS));
    d.wr_rate = 8'(WRITE_RATE);
    d.rd_rate = 8'(RD_RATE);
    d.mv_rate = MOVE_RATE_ZERO;

    if (q.busy) begin
      d.busy_cnt = q.busy_cnt - 32'h1;
      // only stream time is charged to the sub-unit
      if (q.stream_on) begin
        d.sub_cyc = q.sub_cyc + 32'h1;
      end
      if (q.table_on) begin
        d.tfw_acc = q.tfw_acc + 32'h1;
      end
      if (q.busy_cnt == 32'h1) begin
        d.busy = 1'b0;
        d.stream_on = 1'b0;
        d.table_on = 1'b0;
        d.dir_close = 1'b0;
        if (q.stream_on && (q.sub_blk >= SUB_BLOCKS)) begin
          d.sub_done = 1'b1;
          d.sub_res = q.sub_cyc + 32'h1;
          d.sub_blk = q.sub_blk - SUB_BLOCKS;
          d.sub_cyc = '0;
        end
        if (q.dir_close) begin
          d.tfw_hist = {q.tfw_hist[TFW_DEPTH-2:0], q.tfw_acc + 32'h1};
          d.tfw_acc = '0;
          for (int i = 0; i < TFW_DEPTH; i++) begin
            sum = sum + 35'(d.tfw_hist[i]);
          end
          if (q.tfw_n != 4'(TFW_DEPTH)) begin
            d.tfw_n = q.tfw_n + 4'h1;
          end
          // the average is only defined once eight cycles are in the window
          if ((d.tfw_n == 4'(TFW_DEPTH)) && (32'(sum >> TFW_SHIFT) > q.tfw_ave)) begin
            d.tfw_ave = 32'(sum >> TFW_SHIFT);
          end
        end
      end
    end

    if (take) begin
      d.busy = 1'b1;
      d.busy_cnt = 32'h1;
      unique case (q.sy2.op)
        OP_IDLE: begin
          d.busy = 1'b0;
        end
        OP_START_REC: begin
          if (q.dir_ok) begin
            d.rec = 1'b1;
            d.busy_cnt = 32'(REC_CYC);
            d.sub_blk = '0;
            d.sub_cyc = '0;
            d.tfw_acc = '0;
            d.tfw_n = '0;
            d.tfw_ave = '0;
          end
        end
        OP_UPDATE_DIR: begin
          d.rec = 1'b0;
          d.dir_arm = 1'b1;
          d.ci_arm = 1'b0;
          d.busy_cnt = 32'(UPD_CYC);
        end
        OP_UPDATE_CI: begin
          d.ci_arm = q.rec;
          d.busy_cnt = 32'(UPD_CYC);
        end
        OP_WRITE: begin
          d.wr_valid = 1'b1;
          d.wr_addr = q.sy2.addr;
          d.wr_len = q.sy2.len;
          d.ci_arm = 1'b0;
          d.busy_cnt = wcyc;
          if (q.dir_arm) begin
            d.wr_kind = WK_DIR;
            d.dir_addr = q.sy2.addr;
            d.dir_ok = 1'b1;
            d.dir_arm = 1'b0;
          end else if (q.rec && q.ci_arm && (q.sy2.len == 16'(ENTRY_BLK))) begin
            d.wr_kind = WK_CI;
            d.busy_cnt = 32'(CI_CYC);
          end else if (q.rec && (q.sy2.len == 16'(ENTRY_BLK)) &&
                       (q.sy2.addr == q.dir_addr)) begin
            d.wr_kind = WK_DIR;
            d.table_on = 1'b1;
            d.dir_close = 1'b1;
          end else if (q.rec && (q.sy2.len == q.ru_blk)) begin
            d.wr_kind = WK_STREAM;
            d.stream_on = 1'b1;
            d.sub_blk = q.sub_blk + 32'(q.sy2.len);
          end else if (q.rec) begin
            d.wr_kind = WK_TABLE;
            d.table_on = 1'b1;
          end else begin
            d.wr_kind = WK_PLAIN;
          end
        end
        default: begin
          d.busy = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lnk.busy = q.busy;
  assign WR_VALID = q.wr_valid;
  assign WR_KIND = q.wr_kind;
  assign WR_ADDR = q.wr_addr;
  assign WR_LEN = q.wr_len;
  assign RECORDING = q.rec;
  assign SUB_DONE = q.sub_done;
  assign SUB_CYCLES = q.sub_res;
  assign TFW_AVE = q.tfw_ave;
  assign MOVE_RATE = q.mv_rate;
  assign WRITE_RATE_MIN = q.wr_rate;
  assign READ_RATE_MIN = q.rd_rate;
  assign RU_BLOCKS = q.ru_blk;
  assign BUS_MHZ = q.bus_mhz;
  assign CLASS_MASK = q.cls_mask;
  assign AU_OK = q.au_ok;
endmodule

// ==== tb/scrs_checker.sv ====
// link checks between the host and card ends
`timescale 1ns/1ps
module scrs_checker
  import scrs_pkg::*;
#(
  parameter int unsigned SPEED_CLASS = 10,
  parameter int unsigned BLK_CYC = 1,
  parameter int unsigned UPD_CYC = 20,
  parameter int unsigned REC_CYC = 50,
  parameter int unsigned CI_CYC = 30
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire scrs_link_t cmd,
  input wire logic busy
);
  localparam int unsigned RU_BLK = ((SPEED_CLASS >= 10) ? RU_KB_C10 : RU_KB_STD) * BLK_PER_KB;
  typedef struct packed {
    scrs_op_t op;
    scrs_op_t prev;
    logic [15:0] len;
    logic [31:0] cnt;
  } scrs_chk_t;
  scrs_chk_t st_q;
  scrs_chk_t st_d;
  logic b_rise;
  logic b_end;
  assign b_rise = busy && (st_q.cnt == 32'h0);
  assign b_end = !busy && (st_q.cnt != 32'h0);
  // op latched as busy rises: the link fields still hold the taken command then
  always_comb begin
    st_d = st_q;
    st_d.cnt = busy ? st_q.cnt + 32'h1 : 32'h0;
    if (b_rise) begin
      st_d.prev = st_q.op;
      st_d.op = cmd.op;
      st_d.len = cmd.len;
    end
  end
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  default clocking dflt_cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  sequence lclk_high2;
    cmd.lclk ##1 !cmd.lclk;
  endsequence
  sequence valid_over_rise;
    (cmd.valid && !cmd.lclk) ##[1:4] (cmd.valid && cmd.lclk);
  endsequence
  upd_busy_a: assert property (
    b_end && (st_q.op inside {OP_UPDATE_DIR, OP_UPDATE_CI}) |-> st_q.cnt == UPD_CYC)
    else $error("update busy length wrong");
  rec_busy_a: assert property (
    b_end && st_q.op == OP_START_REC |-> st_q.cnt == REC_CYC || st_q.cnt == 32'h1)
    else $error("start busy length wrong");
  ci_time_a: assert property (
    b_end && st_q.op == OP_WRITE && st_q.prev == OP_UPDATE_CI && st_q.len == 16'h1
    |-> st_q.cnt <= CI_CYC) else $error("info write too long");
  wr_busy_a: assert property (
    b_end && st_q.op == OP_WRITE && st_q.prev != OP_UPDATE_CI
    |-> st_q.cnt == ((st_q.len == 16'h0) ? 32'h1 : 32'(st_q.len)) * BLK_CYC)
    else $error("write busy length wrong");
  ci_single_a: assert property (
    b_rise && cmd.op == OP_WRITE && st_q.op == OP_UPDATE_CI |-> cmd.len == 16'h1)
    else $error("info write not single block");
  dir_single_a: assert property (
    b_rise && cmd.op == OP_WRITE && st_q.op == OP_UPDATE_DIR |-> cmd.len == 16'h1)
    else $error("entry write not single block");
  wr_size_a: assert property (
    b_rise && cmd.op == OP_WRITE
    |-> (cmd.len != 16'h0 && cmd.len <= FAT_MAX_BLK) || cmd.len == RU_BLK)
    else $error("write length out of range");
  lclk_rate_a: assert property (
    $rose(cmd.lclk) |=> lclk_high2) else $error("link clock too slow");
  idle_req_a: assert property (
    $rose(cmd.valid) |-> !busy) else $error("command while busy");
  valid_frame_a: assert property (
    $rose(cmd.valid) |-> valid_over_rise) else $error("valid misses link edge");
endmodule

// ==== tb/test_speed_class_recording_sequencer.sv ====
// bench joining host and card ends, plus a hand-driven card
`timescale 1ns/1ps
module test_speed_class_recording_sequencer
  import scrs_pkg::*;
;
  localparam int unsigned UPD = 20;
  localparam int unsigned REC = 50;
  localparam int unsigned CIC = 30;
  logic CLOCK = 1'h0;
  logic RST = 1'h1;
  logic job_valid = 1'h0;
  scrs_job_t job_op = J_DIR;
  logic [31:0] job_addr = 32'h0;
  logic [31:0] job_addr2 = 32'h0;
  logic [15:0] job_len = 16'h0;
  logic [15:0] job_len2 = 16'h0;
  logic job_ready, job_done, job_err, wr_valid, recording, sub_done, au_ok, au_ok_x, wr_valid_x;
  scrs_kind_t wr_kind, wr_kind_x;
  logic [31:0] wr_addr, sub_cycles, tfw_ave;
  logic [15:0] wr_len, ru_blocks;
  logic [7:0] move_rate, wr_rate, rd_rate, bus_mhz;
  logic [3:0] class_mask;
  logic [50:0] wq[$];
  scrs_kind_t kq[$];
  int errors = 0;
  int samples_checked = 0;
  int subs = 0;
  scrs_link_if lnk ();
  scrs_link_if lnk2 ();
  scrs_host #(.AU_KB(1024)) scrs_host_i (.CLOCK(CLOCK), .RST(RST), .lnk(lnk.host),
    .JOB_VALID(job_valid), .JOB_READY(job_ready), .JOB_OP(job_op), .JOB_ADDR(job_addr),
    .JOB_LEN(job_len), .JOB_ADDR2(job_addr2), .JOB_LEN2(job_len2), .JOB_DONE(job_done),
    .JOB_ERR(job_err));
  scrs_card #(.AU_KB(1024), .READ_RATE(8), .UPD_CYC(UPD), .REC_CYC(REC), .CI_CYC(CIC))
  scrs_card_i (.CLOCK(CLOCK), .RST(RST), .lnk(lnk.card), .WR_VALID(wr_valid),
    .WR_KIND(wr_kind), .WR_ADDR(wr_addr), .WR_LEN(wr_len), .RECORDING(recording),
    .SUB_DONE(sub_done), .SUB_CYCLES(sub_cycles), .TFW_AVE(tfw_ave), .MOVE_RATE(move_rate),
    .WRITE_RATE_MIN(wr_rate), .READ_RATE_MIN(rd_rate), .RU_BLOCKS(ru_blocks),
    .BUS_MHZ(bus_mhz), .CLASS_MASK(class_mask), .AU_OK(au_ok));
  // 6MB unit: above 4MB but not a multiple of it
  scrs_card #(.AU_KB(6144), .UPD_CYC(UPD), .REC_CYC(REC), .CI_CYC(CIC))
  scrs_card_x_i (.CLOCK(CLOCK), .RST(RST), .lnk(lnk2.card), .WR_VALID(wr_valid_x),
    .WR_KIND(wr_kind_x), .WR_ADDR(), .WR_LEN(), .RECORDING(), .SUB_DONE(), .SUB_CYCLES(),
    .TFW_AVE(), .MOVE_RATE(), .WRITE_RATE_MIN(), .READ_RATE_MIN(), .RU_BLOCKS(),
    .BUS_MHZ(), .CLASS_MASK(), .AU_OK(au_ok_x));
  scrs_checker #(.UPD_CYC(UPD), .REC_CYC(REC), .CI_CYC(CIC)) scrs_checker_i (.CLOCK(CLOCK),
    .RST(RST), .cmd(lnk.cmd), .busy(lnk.busy));
  initial begin
    forever #2.5 CLOCK = ~CLOCK;
  end
  // pulses last a full cycle, so the falling edge sees each one once
  always @(negedge CLOCK) begin
    if (wr_valid === 1'h1) wq.push_back({wr_kind, wr_addr, wr_len});
    if (wr_valid_x === 1'h1) kq.push_back(wr_kind_x);
    if (sub_done === 1'h1) subs++;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic jb(input scrs_job_t op, input logic [31:0] a, input logic [15:0] l,
      input logic [31:0] a2, input logic [15:0] l2, input logic e);
    int n;
    n = 0;
    @(negedge CLOCK);
    while (job_ready !== 1'h1 && n < 100) begin
      @(negedge CLOCK);
      n++;
    end
    job_op = op;
    job_addr = a;
    job_len = l;
    job_addr2 = a2;
    job_len2 = l2;
    job_valid = 1'h1;
    @(negedge CLOCK);
    job_valid = 1'h0;
    n = 0;
    while (job_done !== 1'h1 && job_err !== 1'h1 && n < 5000) begin
      @(negedge CLOCK);
      n++;
    end
    check("job_end", 32'(job_done | job_err), 32'h1);
    check("job_err", 32'(job_err), 32'(e));
  endtask
  task automatic expw(input scrs_kind_t k, input logic [31:0] a, input logic [15:0] l);
    logic [50:0] w;
    w = (wq.size() > 0) ? wq.pop_front() : 'x;
    check("wr_kind", 32'(w[50:48]), 32'(k));
    check("wr_addr", w[47:16], a);
    check("wr_len", 32'(w[15:0]), 32'(l));
  endtask
  // frames only: the link clock stands low between commands
  task automatic send2(input scrs_op_t op, input logic [15:0] l);
    @(negedge CLOCK);
    lnk2.cmd = '{lclk: 1'h0, valid: 1'h1, op: op, addr: 32'h80, len: l};
    repeat (8) @(negedge CLOCK);
    lnk2.cmd.lclk = 1'h1;
    repeat (8) @(negedge CLOCK);
    lnk2.cmd.lclk = 1'h0;
    lnk2.cmd.valid = 1'h0;
  endtask
  task automatic t_static();
    check("move_rate", 32'(move_rate), 32'(MOVE_RATE_ZERO));
    check("ru_blocks", 32'(ru_blocks), 32'(RU_KB_C10 * BLK_PER_KB));
    check("bus_mhz", 32'(bus_mhz), 32'(BUS_MHZ_HS));
    check("class_mask", 32'(class_mask), 32'hF);
    check("au_ok", 32'(au_ok), 32'h1);
    check("au_bad", 32'(au_ok_x), 32'h0);
    check("read_rate", 32'(rd_rate), 32'hA);
    check("write_rate", 32'(wr_rate), 32'hA);
  endtask
  task automatic t_order();
    jb(J_START, 32'h0, 16'h0, 32'h0, 16'h0, 1'h1);
    jb(J_RU, 32'h1000, 16'h0, 32'h0, 16'h0, 1'h1);
    jb(J_DIR, 32'h100, 16'h1, 32'h0, 16'h0, 1'h0);
    expw(WK_DIR, 32'h100, 16'h1);
    jb(J_START, 32'h0, 16'h0, 32'h0, 16'h0, 1'h0);
    check("recording", 32'(recording), 32'h1);
  endtask
  task automatic t_stream();
    jb(J_RU, 32'h1000, 16'h0, 32'h0, 16'h0, 1'h0);
    expw(WK_STREAM, 32'h1000, 16'h400);
    jb(J_TABLE, 32'h40, 16'h20, 32'h80, 16'h1, 1'h0);
    expw(WK_TABLE, 32'h40, 16'h20);
    expw(WK_TABLE, 32'h80, 16'h1);
    expw(WK_DIR, 32'h100, 16'h1);
    jb(J_CI, 32'h23E, 16'h1, 32'h0, 16'h0, 1'h0);
    expw(WK_CI, 32'h23E, 16'h1);
    jb(J_RU, 32'h0, 16'h0, 32'h0, 16'h0, 1'h0);
    expw(WK_STREAM, 32'h1400, 16'h400);
    check("sub_done", 32'(subs), 32'h1);
    check("sub_cycles", sub_cycles, 32'(2 * RU_KB_C10 * BLK_PER_KB));
  endtask
  task automatic t_refuse();
    jb(J_TABLE, 32'h40, 16'h21, 32'h80, 16'h1, 1'h1);
    jb(J_TABLE, 32'h40, 16'h1, 32'h80, 16'h0, 1'h1);
    jb(J_TABLE, 32'h40, 16'h1, 32'h80, 16'h21, 1'h1);
    check("refused_writes", 32'(wq.size()), 32'h0);
  endtask
  task automatic t_ci();
    logic [31:0] ca [4];
    logic [15:0] cl [4];
    logic [31:0] cx [4];
    logic [3:0] ce;
    ca = '{32'h0, 32'h0, 32'h301, 32'h300};
    cl = '{16'h1, 16'h0, 16'h1, 16'h1};
    cx = '{32'h23F, 32'h23F, 32'h0, 32'h300};
    ce = 4'h4;
    for (int i = 0; i < 4; i++) begin
      jb(J_CI, ca[i], cl[i], 32'h0, 16'h0, ce[i]);
      if (!ce[i]) expw(WK_CI, cx[i], 16'h1);
    end
  endtask
  task automatic t_tfw();
    repeat (8) begin
      jb(J_TABLE, 32'h40, 16'h20, 32'h80, 16'h20, 1'h0);
    end
    wq.delete();
    check("tfw_ave", tfw_ave, 32'(2 * FAT_MAX_BLK + ENTRY_BLK));
  endtask
  task automatic t_end();
    jb(J_DIR, 32'h100, 16'h1, 32'h0, 16'h0, 1'h0);
    expw(WK_DIR, 32'h100, 16'h1);
    check("recording_end", 32'(recording), 32'h0);
    jb(J_RU, 32'h2000, 16'h0, 32'h0, 16'h0, 1'h1);
    // info update after recording: no arm, so the card files it as a plain write
    jb(J_CI, 32'h0, 16'h1, 32'h0, 16'h0, 1'h0);
    expw(WK_PLAIN, 32'h301, 16'h1);
  endtask
  task automatic t_fault();
    send2(OP_UPDATE_DIR, 16'h0);
    send2(OP_WRITE, 16'h5);
    repeat (40) @(negedge CLOCK);
    send2(OP_WRITE, 16'h1);
    send2(OP_START_REC, 16'h0);
    repeat (60) @(negedge CLOCK);
    send2(OP_UPDATE_CI, 16'h0);
    repeat (30) @(negedge CLOCK);
    send2(OP_WRITE, 16'h8);
    repeat (20) @(negedge CLOCK);
    check("fault_writes", 32'(kq.size()), 32'h2);
    check("fault_kind0", 32'(kq[0]), 32'(WK_DIR));
    check("fault_kind1", 32'(kq[1]), 32'(WK_TABLE));
  endtask
  task automatic conclude();
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    lnk2.cmd = '0;
    repeat (12) @(negedge CLOCK);
    RST = 1'h0;
    repeat (3) @(negedge CLOCK);
    t_static();
    t_order();
    t_stream();
    t_refuse();
    t_ci();
    t_tfw();
    t_end();
    t_fault();
    conclude();
  end
  initial begin
    repeat (40000) @(posedge CLOCK);
    errors++;
    conclude();
  end
endmodule
